// [dram_cmd_pkg.sv]
// shared constants and types of the memory command decoder
package dram_cmd_pkg;

  localparam int BANK_W         = 3;
  localparam int BANKS          = 8;
  localparam int ADDR_W         = 14;
  localparam int AUTOCLOSE_POS  = 10;   // autoclose_bit on the address lines
  localparam int CHOP_POS       = 12;   // chop_select on the address lines
  localparam int CORE_MHZ       = 25;
  localparam int EXIT_WAIT_NS   = 170;  // exit_wait_time, plain default
  localparam int EXIT_WAIT_CYC  = (EXIT_WAIT_NS * CORE_MHZ + 999) / 1000;
  localparam int EXIT_LOCK_CYC  = 512;  // exit_lock_wait in cycles
  localparam int TIMER_W        = 10;
  localparam int FULL_BURST_CYC = 4;    // full_burst: eight beats, two per cycle
  localparam int CHOP_BURST_CYC = 2;    // chopped_burst: four beats
  localparam int BURST_W        = 3;
  localparam int COUNT_W        = 8;

  typedef enum logic [3:0] {
    deselect_cmd, idle_cmd, config_write_cmd, refresh_cmd, row_open_cmd,
    close_row_cmd, close_all_rows_cmd, store_cmd, fetch_cmd, calib_cmd
  } cmd_kind_t;

  typedef enum logic [2:0] {
    pwr_idle, pwr_active, pwr_standby_pre, pwr_standby_act, pwr_retain
  } pwr_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_strobe_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } pins_t;

  typedef struct packed {
    cmd_kind_t         kind;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              autoclose;
    logic              full;
  } cmd_word_t;

  typedef struct packed {
    pwr_state_t         state;
    logic [BANKS-1:0]   open_banks;
    logic               burst_busy;
    logic               all_idle;
    logic               fetch_ready;
    logic               fault_seen;
    logic [COUNT_W-1:0] cmd_count;
    cmd_word_t          last_cmd;
  } status_t;

  localparam int STATUS_W = $bits(status_t);

endpackage

// [level_sync.sv]
// two-flop synchroniser for independent level signals
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg;

endmodule

// [word_xfer.sv]
// toggle handshake moving a snapshot word from the link to the core clock
`timescale 1ns/1ps
module word_xfer #(
  parameter int WIDTH = 8
) (
  input  wire logic             src_clk_i,
  input  wire logic             src_rst_n_i,
  input  wire logic [WIDTH-1:0] src_data_i,
  input  wire logic             dst_clk_i,
  input  wire logic             dst_rst_i,
  output logic      [WIDTH-1:0] dst_data_o,
  output logic                  dst_valid_o
);

  logic             req_reg, req_next;
  logic [WIDTH-1:0] hold_reg, hold_next;
  logic             ack_meta_reg, ack_sync_reg;
  logic             req_meta_reg, req_sync_reg;
  logic             seen_reg, seen_next;
  logic [WIDTH-1:0] data_reg, data_next;
  logic             valid_reg, valid_next;

  // source: a new word is held only after the last one was taken
  always_comb begin
    req_next  = req_reg;
    hold_next = hold_reg;
    if (req_reg == ack_sync_reg) begin
      hold_next = src_data_i;
      req_next  = ~req_reg;
    end
  end

  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      req_reg      <= 1'b0;
      hold_reg     <= '0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      req_reg      <= req_next;
      hold_reg     <= hold_next;
      ack_meta_reg <= seen_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // destination: hold_reg is stable while the request is pending
  always_comb begin
    seen_next  = seen_reg;
    data_next  = data_reg;
    valid_next = 1'b0;
    if (req_sync_reg != seen_reg) begin
      seen_next  = req_sync_reg;
      data_next  = hold_reg;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      seen_reg     <= 1'b0;
      data_reg     <= '0;
      valid_reg    <= 1'b0;
    end else begin
      req_meta_reg <= req_reg;
      req_sync_reg <= req_meta_reg;
      seen_reg     <= seen_next;
      data_reg     <= data_next;
      valid_reg    <= valid_next;
    end
  end

  assign dst_data_o  = data_reg;
  assign dst_valid_o = valid_reg;

  a_hold_stable: assert property (@(posedge src_clk_i) disable iff (!src_rst_n_i)
    (req_reg != ack_sync_reg) |=> $stable(hold_reg))
    else $error("snapshot changed while in flight");

  c_word_moved: cover property (@(posedge dst_clk_i) disable iff (dst_rst_i)
    valid_reg);

endmodule

// [dram_command_decoder.sv]
// command decoder and clock-gate state tracker of an eight-bank memory
`timescale 1ns/1ps
module dram_command_decoder (
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_i,
  input  wire logic                           mem_clk_i,
  input  wire logic                           mem_reset_n_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           row_strobe_n_i,
  input  wire logic                           col_strobe_n_i,
  input  wire logic                           write_strobe_n_i,
  input  wire logic                           gate_i,
  input  wire logic [dram_cmd_pkg::BANK_W-1:0] bank_i,
  input  wire logic [dram_cmd_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                           termination_control_i,
  input  wire logic                           cfg_otf_i,
  input  wire logic                           cfg_fixed_chop_i,
  output logic                                term_enable_o,
  output dram_cmd_pkg::status_t               status_o,
  output logic                                status_valid_o
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // strobe pattern to command; the gate is judged separately
  function automatic dram_cmd_pkg::cmd_kind_t decode(input dram_cmd_pkg::pins_t p);
    logic [2:0] s;
    s = {p.row_strobe_n, p.col_strobe_n, p.write_strobe_n};
    if (p.cs_n) begin
      decode = dram_cmd_pkg::deselect_cmd;
    end else begin
      unique case (s)
        3'h0: decode = dram_cmd_pkg::config_write_cmd;
        3'h1: decode = dram_cmd_pkg::refresh_cmd;
        3'h2: decode = p.addr[dram_cmd_pkg::AUTOCLOSE_POS] ?
                       dram_cmd_pkg::close_all_rows_cmd :
                       dram_cmd_pkg::close_row_cmd;
        3'h3: decode = dram_cmd_pkg::row_open_cmd;
        3'h4: decode = dram_cmd_pkg::store_cmd;
        3'h5: decode = dram_cmd_pkg::fetch_cmd;
        3'h6: decode = dram_cmd_pkg::calib_cmd;
        3'h7: decode = dram_cmd_pkg::idle_cmd;
      endcase
    end
  endfunction

  function automatic logic [dram_cmd_pkg::BANKS-1:0] bank_mask(
    input logic [dram_cmd_pkg::BANK_W-1:0] b);
    bank_mask = '0;
    bank_mask[b] = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // link domain: configuration crossing and command decode

  dram_cmd_pkg::pins_t     pins;
  dram_cmd_pkg::cmd_kind_t cmd;
  logic [1:0]              cfg_sync;
  logic                    nop_like;

  level_sync #(.WIDTH(2)) u_cfg_sync (
    .clk_i   (mem_clk_i),
    .rst_n_i (mem_reset_n_i),
    .d_i     ({cfg_otf_i, cfg_fixed_chop_i}),
    .q_o     (cfg_sync)
  );

  // termination pin deliberately absent from this bundle
  always_comb begin
    pins = '{cs_n: cs_n_i, row_strobe_n: row_strobe_n_i,
             col_strobe_n: col_strobe_n_i, write_strobe_n: write_strobe_n_i,
             bank: bank_i, addr: addr_i};
    cmd      = decode(pins);
    nop_like = (cmd == dram_cmd_pkg::deselect_cmd) ||
               (cmd == dram_cmd_pkg::idle_cmd);
  end

  ////////////////////////////////////////////////////////////////////
  // link domain state

  dram_cmd_pkg::pwr_state_t             pwr_reg, pwr_next;
  logic                                 gate_prev_reg, gate_prev_next;
  logic [dram_cmd_pkg::BANKS-1:0]       banks_reg, banks_next;
  logic [dram_cmd_pkg::BURST_W-1:0]     burst_reg, burst_next;
  logic                                 close_pend_reg, close_pend_next;
  logic [dram_cmd_pkg::BANK_W-1:0]      close_bank_reg, close_bank_next;
  logic [dram_cmd_pkg::TIMER_W-1:0]     exit_cnt_reg, exit_cnt_next;
  logic [dram_cmd_pkg::TIMER_W-1:0]     lock_cnt_reg, lock_cnt_next;
  logic [dram_cmd_pkg::COUNT_W-1:0]     cmd_cnt_reg, cmd_cnt_next;
  dram_cmd_pkg::cmd_word_t              last_reg, last_next;
  logic                                 fault_reg, fault_next;
  logic                                 term_reg, term_next;
  logic                                 powered, burst_busy, all_idle, full;
  logic [dram_cmd_pkg::BANKS-1:0]       banks_after;
  dram_cmd_pkg::status_t                snap;

  always_comb begin
    powered    = (pwr_reg == dram_cmd_pkg::pwr_idle) ||
                 (pwr_reg == dram_cmd_pkg::pwr_active);
    burst_busy = (burst_reg != '0);
    // banks as they stand once the running burst and its close finish
    banks_after = (close_pend_reg && burst_busy) ?
                  (banks_reg & ~bank_mask(close_bank_reg)) : banks_reg;
    all_idle   = powered && (banks_reg == '0) && !burst_busy &&
                 (exit_cnt_reg == '0);
    // fixed or on-the-fly length as configured
    full       = cfg_sync[1] ? addr_i[dram_cmd_pkg::CHOP_POS] :
                 !cfg_sync[0];
  end

  // next state: one decision per link edge against the held state
  always_comb begin
    pwr_next        = pwr_reg;
    gate_prev_next  = gate_i;
    banks_next      = banks_reg;
    burst_next      = burst_reg;
    close_pend_next = close_pend_reg;
    close_bank_next = close_bank_reg;
    exit_cnt_next   = (exit_cnt_reg != '0) ? exit_cnt_reg - 1'b1 : exit_cnt_reg;
    lock_cnt_next   = (lock_cnt_reg != '0) ? lock_cnt_reg - 1'b1 : lock_cnt_reg;
    cmd_cnt_next    = cmd_cnt_reg;
    last_next       = last_reg;
    fault_next      = fault_reg;

    // a running burst always counts out; idle or standby never stops it
    if (burst_busy) begin
      burst_next = burst_reg - 1'b1;
      if (burst_reg == 3'h1 && close_pend_reg) begin
        banks_next      = banks_reg & ~bank_mask(close_bank_reg);
        close_pend_next = 1'b0;
      end
    end

    unique case (pwr_reg)
      dram_cmd_pkg::pwr_retain: begin
        // clock may have stopped, so no earlier gate sample is consulted
        if (gate_i) begin
          pwr_next      = dram_cmd_pkg::pwr_idle;
          exit_cnt_next = dram_cmd_pkg::TIMER_W'(dram_cmd_pkg::EXIT_WAIT_CYC);
          lock_cnt_next = dram_cmd_pkg::TIMER_W'(dram_cmd_pkg::EXIT_LOCK_CYC);
          fault_next    = fault_reg | !nop_like;
        end
      end
      dram_cmd_pkg::pwr_standby_pre, dram_cmd_pkg::pwr_standby_act: begin
        if (gate_i) begin
          // banks stay open through standby, so return by bank state
          pwr_next   = (banks_reg != '0) ? dram_cmd_pkg::pwr_active :
                       dram_cmd_pkg::pwr_idle;
          fault_next = fault_reg | !nop_like;
        end
      end
      default: begin
        if (gate_prev_reg && !gate_i) begin
          if (cmd == dram_cmd_pkg::refresh_cmd && all_idle) begin
            pwr_next = dram_cmd_pkg::pwr_retain;
          end else if (nop_like) begin
            pwr_next = (banks_after == '0) ? dram_cmd_pkg::pwr_standby_pre :
                       dram_cmd_pkg::pwr_standby_act;
          end else begin
            fault_next = 1'b1;
          end
        end else if (gate_i && !nop_like) begin
          cmd_cnt_next = cmd_cnt_reg + 1'b1;
          last_next    = '{kind: cmd, bank: bank_i, addr: addr_i,
                           autoclose: addr_i[dram_cmd_pkg::AUTOCLOSE_POS],
                           full: full};
          unique case (cmd)
            dram_cmd_pkg::refresh_cmd:
              fault_next = fault_reg | !all_idle;
            dram_cmd_pkg::row_open_cmd:
              // builds on banks_next so an autoclose on this edge is kept
              banks_next = banks_next | bank_mask(bank_i);
            dram_cmd_pkg::close_row_cmd:
              banks_next = banks_next & ~bank_mask(bank_i);
            dram_cmd_pkg::close_all_rows_cmd:
              banks_next = '0;
            dram_cmd_pkg::store_cmd, dram_cmd_pkg::fetch_cmd: begin
              // an overlapping burst is refused, never restarted
              if (burst_busy || !banks_reg[bank_i] ||
                  (cmd == dram_cmd_pkg::fetch_cmd && lock_cnt_reg != '0)) begin
                fault_next = 1'b1;
              end else begin
                burst_next = full ?
                  dram_cmd_pkg::BURST_W'(dram_cmd_pkg::FULL_BURST_CYC) :
                  dram_cmd_pkg::BURST_W'(dram_cmd_pkg::CHOP_BURST_CYC);
                close_pend_next = addr_i[dram_cmd_pkg::AUTOCLOSE_POS];
                close_bank_next = bank_i;
              end
            end
            default: ;
          endcase
        end
        if (pwr_next == dram_cmd_pkg::pwr_idle || pwr_next == dram_cmd_pkg::pwr_active) begin
          pwr_next = (banks_next != '0) ? dram_cmd_pkg::pwr_active :
                     dram_cmd_pkg::pwr_idle;
        end
      end
    endcase

    term_next = termination_control_i &&
                (pwr_next != dram_cmd_pkg::pwr_retain);
  end

  // register the link state; reset pin is asynchronous
  always_ff @(posedge mem_clk_i or negedge mem_reset_n_i) begin
    if (!mem_reset_n_i) begin
      pwr_reg        <= dram_cmd_pkg::pwr_idle;
      gate_prev_reg  <= 1'b0;
      banks_reg      <= '0;
      burst_reg      <= '0;
      close_pend_reg <= 1'b0;
      close_bank_reg <= '0;
      exit_cnt_reg   <= '0;
      lock_cnt_reg   <= '0;
      cmd_cnt_reg    <= '0;
      last_reg       <= '0;
      fault_reg      <= 1'b0;
      term_reg       <= 1'b0;
    end else begin
      pwr_reg        <= pwr_next;
      gate_prev_reg  <= gate_prev_next;
      banks_reg      <= banks_next;
      burst_reg      <= burst_next;
      close_pend_reg <= close_pend_next;
      close_bank_reg <= close_bank_next;
      exit_cnt_reg   <= exit_cnt_next;
      lock_cnt_reg   <= lock_cnt_next;
      cmd_cnt_reg    <= cmd_cnt_next;
      last_reg       <= last_next;
      fault_reg      <= fault_next;
      term_reg       <= term_next;
    end
  end

  assign term_enable_o = term_reg;

  ////////////////////////////////////////////////////////////////////
  // status snapshot to the core clock

  dram_cmd_pkg::status_t status_x;
  logic                  status_x_valid;

  // snapshot may skip states faster than the core clock can see
  always_comb begin
    snap = '{state: pwr_reg, open_banks: banks_reg, burst_busy: burst_busy,
             all_idle: all_idle, fetch_ready: (lock_cnt_reg == '0),
             fault_seen: fault_reg, cmd_count: cmd_cnt_reg, last_cmd: last_reg};
  end

  word_xfer #(.WIDTH(dram_cmd_pkg::STATUS_W)) u_status_xfer (
    .src_clk_i   (mem_clk_i),
    .src_rst_n_i (mem_reset_n_i),
    .src_data_i  (snap),
    .dst_clk_i   (core_clk_i),
    .dst_rst_i   (reset_i),
    .dst_data_o  (status_x),
    .dst_valid_o (status_x_valid)
  );

  dram_cmd_pkg::status_t status_reg, status_next;
  logic                  status_valid_reg, status_valid_next;

  // core side outputs straight from flops
  always_comb begin
    status_next       = status_x_valid ? status_x : status_reg;
    status_valid_next = status_x_valid;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_reg       <= '0;
      status_valid_reg <= 1'b0;
    end else begin
      status_reg       <= status_next;
      status_valid_reg <= status_valid_next;
    end
  end

  assign status_o       = status_reg;
  assign status_valid_o = status_valid_reg;

  ////////////////////////////////////////////////////////////////////
  // checks

  a_retain_entry: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (gate_prev_reg && !gate_i && cmd == dram_cmd_pkg::refresh_cmd && all_idle)
    |=> pwr_reg == dram_cmd_pkg::pwr_retain)
    else $error("retain entry missed");
  a_retain_hold: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (pwr_reg == dram_cmd_pkg::pwr_retain && !gate_i)
    |=> pwr_reg == dram_cmd_pkg::pwr_retain)
    else $error("retain state left with gate low");
  a_retain_exit: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (pwr_reg == dram_cmd_pkg::pwr_retain && gate_i)
    |=> powered && exit_cnt_reg == dram_cmd_pkg::TIMER_W'(dram_cmd_pkg::EXIT_WAIT_CYC)
        && !all_idle)
    else $error("retain exit not taken");
  a_standby_kind: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (powered && gate_prev_reg && !gate_i && nop_like)
    |=> pwr_reg == (($past(banks_after) == '0) ? dram_cmd_pkg::pwr_standby_pre :
                    dram_cmd_pkg::pwr_standby_act))
    else $error("wrong standby kind");
  a_row_opens: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (powered && gate_prev_reg && gate_i && cmd == dram_cmd_pkg::row_open_cmd)
    |=> banks_reg[$past(bank_i)])
    else $error("row not opened");
  a_close_all: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (powered && gate_prev_reg && gate_i && cmd == dram_cmd_pkg::close_all_rows_cmd)
    |=> banks_reg == '0)
    else $error("banks not all closed");
  a_burst_runs: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (burst_reg == 3'h4) |=> burst_reg == 3'h3 ##1 burst_reg == 3'h2)
    else $error("burst cut or restarted");
  a_deselect_keeps: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (powered && gate_prev_reg && gate_i && cs_n_i && !burst_busy)
    |=> $stable(banks_reg) && $stable(cmd_cnt_reg))
    else $error("deselect changed state");
  a_term_retain: assert property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    (pwr_reg == dram_cmd_pkg::pwr_retain) |-> !term_enable_o)
    else $error("termination on in retain");

  c_retain: cover property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    pwr_reg == dram_cmd_pkg::pwr_retain ##1 powered);
  c_standby: cover property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    pwr_reg == dram_cmd_pkg::pwr_standby_act);
  c_autoclose: cover property (@(posedge mem_clk_i) disable iff (!mem_reset_n_i)
    burst_reg == 3'h1 && close_pend_reg);

endmodule

// [mem_ctrl_model.sv]
// controller-side model driving the memory command pins
`timescale 1ns/1ps
module mem_ctrl_model #(
  parameter int GATE_HOLD_MIN = 3   // gate_hold_min in link cycles, plain default
) (
  input  wire logic           clk_i,
  output dram_cmd_pkg::pins_t pins_o,
  output logic                gate_o
);
  int edges     = 0;
  int gate_edge = 0;
  initial begin
    pins_o = '1;
    gate_o = 1'b1;
  end
  // free-running edge count, used to space gate changes
  always @(posedge clk_i) begin
    edges <= edges + 1;
  end
  // levels change just after the edge and stand one full cycle
  task automatic send(input logic [3:0] s, input logic [2:0] b, input logic [13:0] a,
                      input logic g);
    @(posedge clk_i);
    // a gate change waits behind deselects until the old level was held long enough
    while (g !== gate_o && edges - gate_edge < GATE_HOLD_MIN) begin
      pins_o <= {4'hf, ~pins_o.bank, ~pins_o.addr};
      @(posedge clk_i);
    end
    if (g !== gate_o) begin
      gate_edge = edges;
    end
    pins_o <= {s, b, a};
    gate_o <= g;
  endtask
  // released lines show inverted address, never the stale value
  task automatic desel(input logic g);
    send(4'hf, ~pins_o.bank, ~pins_o.addr, g);
  endtask
endmodule

// [tb_dram_command_decoder.sv]
// self-checking bench of the command decoder
`timescale 1ns/1ps
module tb_dram_command_decoder;
  logic                  core_clk_i = 1'b0;
  logic                  reset_i    = 1'b1;
  logic                  mem_clk    = 1'b0;
  logic                  mem_rst_n  = 1'b0;
  logic                  otf        = 1'b1;
  logic                  term       = 1'b1;
  logic                  chop       = 1'b0;
  logic                  gate;
  logic                  term_en;
  logic                  sv;
  dram_cmd_pkg::pins_t   pins;
  dram_cmd_pkg::status_t st;
  int                    n_errors    = 0;
  int                    comparisons = 0;
  int                    cycles      = 0;
  always #20 core_clk_i = ~core_clk_i;
  // link clock offset so its edges drift against the core clock
  initial begin
    #3.3;
    forever #7.5 mem_clk = ~mem_clk;
  end
  mem_ctrl_model ctrl (.clk_i(mem_clk), .pins_o(pins), .gate_o(gate));
  dram_command_decoder dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .mem_clk_i(mem_clk),
    .mem_reset_n_i(mem_rst_n), .cs_n_i(pins.cs_n), .row_strobe_n_i(pins.row_strobe_n),
    .col_strobe_n_i(pins.col_strobe_n), .write_strobe_n_i(pins.write_strobe_n),
    .gate_i(gate), .bank_i(pins.bank), .addr_i(pins.addr),
    .termination_control_i(term), .cfg_otf_i(otf), .cfg_fixed_chop_i(chop),
    .term_enable_o(term_en), .status_o(st), .status_valid_o(sv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // snapshots skip states, so wait well past the crossing then take a fresh pulse
  task automatic settle();
    int k;
    repeat (20) @(posedge core_clk_i);
    #1;
    // look just after the edge, where the pulse and its word have settled
    for (k = 0; k < 40 && sv !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_burst();
    ctrl.send(4'b0011, 3'h2, 14'h0155, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.state, dram_cmd_pkg::pwr_active);
    check(st.open_banks, 8'h04);
    ctrl.send(4'b0100, 3'h2, 14'h1408, 1'b1);
    ctrl.send(4'b0111, 3'h2, 14'h0000, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.last_cmd.kind, dram_cmd_pkg::store_cmd);
    check(st.last_cmd.full, 1'b1);
    check(st.open_banks, 8'h00);
    check(st.state, dram_cmd_pkg::pwr_idle);
    ctrl.send(4'b1000, 3'h1, 14'h0000, 1'b1);
    ctrl.send(4'b0000, 3'h3, 14'h0000, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.last_cmd.kind, dram_cmd_pkg::config_write_cmd);
    check(st.cmd_count, 8'h03);
    check(term_en, 1'b1);
    $display("burst test done");
  endtask
  task automatic t_standby();
    ctrl.send(4'b0011, 3'h5, 14'h0000, 1'b1);
    ctrl.desel(1'b1);
    ctrl.desel(1'b0);
    ctrl.send(4'b0000, 3'h0, 14'h0000, 1'b0);
    settle();
    check(st.state, dram_cmd_pkg::pwr_standby_act);
    ctrl.send(4'b0111, 3'h0, 14'h0000, 1'b1);
    ctrl.send(4'b0010, 3'h0, 14'h0400, 1'b1);
    ctrl.desel(1'b1);
    ctrl.desel(1'b0);
    settle();
    check(st.state, dram_cmd_pkg::pwr_standby_pre);
    ctrl.desel(1'b1);
    settle();
    check(st.state, dram_cmd_pkg::pwr_idle);
    $display("standby test done");
  endtask
  // fixed chopped length, plain read, single close, refresh and calibration
  task automatic t_modes();
    @(posedge core_clk_i);
    otf  <= 1'b0;
    chop <= 1'b1;
    term <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    ctrl.send(4'b0011, 3'h3, 14'h0000, 1'b1);
    ctrl.send(4'b0101, 3'h3, 14'h1000, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.last_cmd.kind, dram_cmd_pkg::fetch_cmd);
    check(st.last_cmd.full, 1'b0);
    check(st.open_banks, 8'h08);
    check(term_en, 1'b0);
    ctrl.send(4'b0010, 3'h3, 14'h0000, 1'b1);
    ctrl.send(4'b0001, 3'h0, 14'h0000, 1'b1);
    ctrl.send(4'b0110, 3'h0, 14'h0000, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.open_banks, 8'h00);
    check(st.cmd_count, 8'h0a);
    check(st.state, dram_cmd_pkg::pwr_idle);
    check(st.fault_seen, 1'b0);
    check(st.all_idle, 1'b1);
    check(st.burst_busy, 1'b0);
    @(posedge core_clk_i);
    otf  <= 1'b1;
    chop <= 1'b0;
    term <= 1'b1;
    $display("modes test done");
  endtask
  task automatic t_retain();
    ctrl.send(4'b0001, 3'h0, 14'h0000, 1'b0);
    ctrl.send(4'b0101, 3'h0, 14'h0000, 1'b0);
    settle();
    check(st.state, dram_cmd_pkg::pwr_retain);
    check(term_en, 1'b0);
    ctrl.desel(1'b1);
    settle();
    check(st.state, dram_cmd_pkg::pwr_idle);
    check(st.fetch_ready, 1'b0);
    ctrl.send(4'b0011, 3'h1, 14'h0000, 1'b1);
    ctrl.send(4'b0101, 3'h1, 14'h0000, 1'b1);
    ctrl.desel(1'b1);
    settle();
    check(st.fault_seen, 1'b1);
    $display("retain test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge mem_clk);
    mem_rst_n <= 1'b1;
    settle();
    t_burst();
    t_standby();
    t_modes();
    t_retain();
    end_of_test();
  end
endmodule
